// *** rtl/citmm_data_map.v ***
/*
 Data memory operand decoder: turns an access mode and operand into a data
 byte address and a choice of lower RAM, upper RAM or special function
 register space, plus the bit position for bit operands.
 Assumes the caller supplies the contents of R0/R1 for indirect access.
*/
`timescale 1ns/10ps
`include "citmm_defs.vh"

module citmm_data_map (
    input wire [2:0] access_mode,
    input wire [2:0] reg_index,
    input wire [1:0] bank,
    input wire [7:0] direct_addr,
    input wire [7:0] ri_value,
    output reg [7:0] byte_addr,
    output reg sel_lower,
    output reg sel_upper,
    output reg sel_sfr,
    output reg bit_access,
    output reg [2:0] bit_pos,
    output wire [7:0] reg_addr
);

    assign reg_addr = {3'h0, bank, reg_index};

    always @*
    begin
        byte_addr = 8'h00;
        sel_lower = 1'b0;
        sel_upper = 1'b0;
        sel_sfr = 1'b0;
        bit_access = 1'b0;
        bit_pos = 3'h0;
        if (access_mode == `AM_REG)
        begin
            byte_addr = reg_addr;
            sel_lower = 1'b1;
        end
        else if (access_mode == `AM_DIRECT)
        begin
            byte_addr = direct_addr;
            if (direct_addr <= `LOWER_TOP)
                sel_lower = 1'b1;
            else
                sel_sfr = 1'b1;
        end
        else if (access_mode == `AM_INDIRECT)
        begin
            byte_addr = ri_value;
            if (ri_value <= `LOWER_TOP)
                sel_lower = 1'b1;
            else
                sel_upper = 1'b1;
        end
        else if (access_mode == `AM_BIT)
        begin
            bit_access = 1'b1;
            bit_pos = direct_addr[2:0];
            if (direct_addr <= `LOWER_TOP)
            begin
                byte_addr = `BIT_RAM_BASE | {4'h0, direct_addr[6:3]};
                sel_lower = 1'b1;
            end
            else
            begin
                // Only register addresses ending in 0 or 8 hold bits
                byte_addr = {direct_addr[7:3], 3'h0};
                sel_sfr = 1'b1;
            end
        end
    end

endmodule // citmm_data_map

// *** rtl/citmm_decoder.v ***
/*
 Instruction timing and memory map decoder for a single-clock pipelined
 microcontroller core. Takes one fetched instruction (opcode and up to two
 operand bytes) plus the core state it depends on, and reports its length,
 its clock count, any branch target, the data and code addresses it uses,
 and holds ready low until its clock count has elapsed.
 Assumes all inputs come from logic on ref_clk and are stable while
 instr_valid is high; arithmetic and logic opcodes are decoded elsewhere.
*/
`timescale 1ns/10ps
`include "citmm_defs.vh"

module citmm_decoder (
    input wire ref_clk,
    input wire srst,
    input wire instr_valid,
    input wire [7:0] opcode,
    input wire [7:0] operand_a,
    input wire [7:0] operand_b,
    input wire [15:0] next_pc,
    input wire [7:0] acc_value,
    input wire carry,
    input wire bit_value,
    input wire [7:0] src_value,
    input wire [7:0] ri_value,
    input wire [15:0] data_pointer,
    input wire [7:0] program_status_word,
    input wire [7:0] program_store_control,
    input wire [1:0] flash_variant,
    output reg ready,
    output reg out_valid,
    output reg decoded,
    output reg no_operation,
    output reg [1:0] instr_bytes,
    output reg [2:0] instr_cycles,
    output reg pc_load,
    output reg is_call,
    output reg [15:0] branch_target,
    output reg bit_clear,
    output reg [7:0] data_addr,
    output reg data_lower,
    output reg data_upper,
    output reg data_sfr,
    output reg data_bit,
    output reg [2:0] data_bit_pos,
    output reg [7:0] reg_addr,
    output reg [15:0] code_addr,
    output reg code_read,
    output reg flash_write,
    output reg code_fault
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    reg [1:0] state;
    reg [2:0] remain;

    reg next_known;
    reg next_nop;
    reg [1:0] next_bytes;
    reg [2:0] next_base;
    reg next_cond;
    reg next_cond_true;
    reg next_uncond;
    reg next_call;
    reg next_has_bit_clear;
    reg [15:0] next_target;
    reg [2:0] next_mode;
    reg [2:0] next_reg_idx;
    reg [7:0] next_direct;
    reg next_code_rd;
    reg next_code_wr;
    reg [15:0] next_code_a;

    wire next_taken;
    wire [2:0] next_cycles;
    wire next_fault;
    wire [7:0] map_addr;
    wire map_lower;
    wire map_upper;
    wire map_sfr;
    wire map_bit;
    wire [2:0] map_bit_pos;
    wire [7:0] map_reg_addr;
    wire accept;

    // Base plus an 8-bit offset, sign-extended only when asked
    function [15:0] add_offset;
        input [15:0] base;
        input [7:0] off;
        input sgn;
        begin
            add_offset = base + {{8{sgn & off[7]}}, off};
        end
    endfunction

    // Highest implemented flash address plus one, by variant
    function [15:0] flash_end;
        input [1:0] variant;
        begin
            if (variant == `VAR_8K)
                flash_end = `FLASH_8K_END;
            else if (variant == `VAR_4K)
                flash_end = `FLASH_4K_END;
            else
                flash_end = `FLASH_2K_END;
        end
    endfunction

    assign accept = instr_valid & ready;

    always @*
    begin
        next_known = 1'b1;
        next_nop = 1'b0;
        next_bytes = `BYTES_1;
        next_base = `CYC_1;
        next_cond = 1'b0;
        next_cond_true = 1'b0;
        next_uncond = 1'b0;
        next_call = 1'b0;
        next_has_bit_clear = 1'b0;
        next_target = 16'h0000;
        next_mode = `AM_NONE;
        next_reg_idx = {2'h0, opcode[0]};
        next_direct = operand_a;
        next_code_rd = 1'b0;
        next_code_wr = 1'b0;
        next_code_a = 16'h0000;
        casez (opcode)
            `OP_NOP, `OP_NOP_ALT:
                next_nop = 1'b1;
            `OP_MOV_DP_IMM:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_3;
            end
            `OP_CODE_DP, `OP_CODE_PC:
            begin
                next_base = `CYC_3;
                next_code_rd = 1'b1;
                if (opcode == `OP_CODE_DP)
                    next_code_a = add_offset(data_pointer, acc_value, 1'b0);
                else
                    next_code_a = add_offset(next_pc, acc_value, 1'b0);
            end
            // external data moves target program space
            `OP_XRD_RI, `OP_XWR_RI, `OP_XRD_DP, `OP_XWR_DP:
            begin
                next_base = `CYC_3;
                if (opcode[4])
                    next_code_wr = 1'b1;
                else
                    next_code_rd = 1'b1;
                // The 8-bit forms reach only the first 256 bytes
                if (opcode[1])
                    next_code_a = {8'h00, ri_value};
                else
                    next_code_a = data_pointer;
            end
            `OP_PUSH, `OP_POP:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_2;
                next_mode = `AM_DIRECT;
            end
            `OP_EXCH_RN:
            begin
                next_mode = `AM_REG;
                next_reg_idx = opcode[2:0];
            end
            `OP_EXCH_DIR:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_2;
                next_mode = `AM_DIRECT;
            end
            `OP_EXCH_RI, `OP_NIBX_RI:
            begin
                next_base = `CYC_2;
                next_mode = `AM_INDIRECT;
            end
            `OP_CLR_C, `OP_SET_C, `OP_CPL_C:
                next_base = `CYC_1;
            `OP_CLR_BIT, `OP_SET_BIT, `OP_CPL_BIT, `OP_ANL_BIT, `OP_ANL_NBIT,
            `OP_ORL_BIT, `OP_ORL_NBIT, `OP_MOV_C_BIT, `OP_MOV_BIT_C:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_2;
                next_mode = `AM_BIT;
            end
            `OP_JMP_CSET, `OP_JMP_CCLR, `OP_JMP_AZ, `OP_JMP_ANZ:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_2;
                next_cond = 1'b1;
                next_target = add_offset(next_pc, operand_a, 1'b1);
                if (opcode == `OP_JMP_CSET)
                    next_cond_true = carry;
                else if (opcode == `OP_JMP_CCLR)
                    next_cond_true = ~carry;
                else if (opcode == `OP_JMP_AZ)
                    next_cond_true = (acc_value == 8'h00);
                else
                    next_cond_true = (acc_value != 8'h00);
            end
            `OP_JMP_BSET, `OP_JMP_BCLR, `OP_JMP_BSC:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_3;
                next_cond = 1'b1;
                next_mode = `AM_BIT;
                next_target = add_offset(next_pc, operand_b, 1'b1);
                if (opcode == `OP_JMP_BCLR)
                    next_cond_true = ~bit_value;
                else
                    next_cond_true = bit_value;
                next_has_bit_clear = (opcode == `OP_JMP_BSC);
            end
            `OP_SHORT_CALL, `OP_SHORT_JUMP:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_3;
                next_uncond = 1'b1;
                next_call = opcode[4];
                next_target = {next_pc[15:11], opcode[7:5], operand_a};
            end
            `OP_LONG_CALL, `OP_LONG_JUMP:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_4;
                next_uncond = 1'b1;
                next_call = (opcode == `OP_LONG_CALL);
                next_target = {operand_a, operand_b};
            end
            // Returns: target comes from the stack, outside this block
            `OP_RET, `OP_RET_INT:
                next_base = `CYC_5;
            `OP_REL_JUMP:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_3;
                next_uncond = 1'b1;
                next_target = add_offset(next_pc, operand_a, 1'b1);
            end
            `OP_JMP_IND:
            begin
                next_base = `CYC_3;
                next_uncond = 1'b1;
                next_target = add_offset(data_pointer, acc_value, 1'b0);
            end
            `OP_CMPJ_DIR, `OP_CMPJ_IMM, `OP_CMPJ_RN:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_3;
                next_cond = 1'b1;
                next_target = add_offset(next_pc, operand_b, 1'b1);
                if (opcode == `OP_CMPJ_DIR)
                begin
                    next_mode = `AM_DIRECT;
                    next_cond_true = (acc_value != src_value);
                end
                else if (opcode == `OP_CMPJ_IMM)
                    next_cond_true = (acc_value != operand_a);
                else
                begin
                    next_mode = `AM_REG;
                    next_reg_idx = opcode[2:0];
                    next_cond_true = (src_value != operand_a);
                end
            end
            `OP_CMPJ_RI:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_4;
                next_cond = 1'b1;
                next_mode = `AM_INDIRECT;
                next_target = add_offset(next_pc, operand_b, 1'b1);
                next_cond_true = (src_value != operand_a);
            end
            `OP_DECJ_RN:
            begin
                next_bytes = `BYTES_2;
                next_base = `CYC_2;
                next_cond = 1'b1;
                next_mode = `AM_REG;
                next_reg_idx = opcode[2:0];
                next_target = add_offset(next_pc, operand_a, 1'b1);
                next_cond_true = (src_value != 8'h01);
            end
            `OP_DECJ_DIR:
            begin
                next_bytes = `BYTES_3;
                next_base = `CYC_3;
                next_cond = 1'b1;
                next_mode = `AM_DIRECT;
                next_target = add_offset(next_pc, operand_b, 1'b1);
                next_cond_true = (src_value != 8'h01);
            end
            // Arithmetic and logic opcodes are timed by another decoder
            default:
                next_known = 1'b0;
        endcase
    end

    // untaken branch costs one cycle less
    assign next_taken = next_uncond | (next_cond & next_cond_true);
    assign next_cycles = next_base + {2'h0, next_cond & next_cond_true};

    assign next_fault = (next_code_a >= flash_end(flash_variant)) |
                        (next_code_wr & (flash_variant == `VAR_8K) & (next_code_a >= `FLASH_USER_END));

    citmm_data_map u_data_map (
        .access_mode(next_mode),
        .reg_index(next_reg_idx),
        .bank(program_status_word[`STATUS_BANK_HI:`STATUS_BANK_LO]),
        .direct_addr(next_direct),
        .ri_value(ri_value),
        .byte_addr(map_addr),
        .sel_lower(map_lower),
        .sel_upper(map_upper),
        .sel_sfr(map_sfr),
        .bit_access(map_bit),
        .bit_pos(map_bit_pos),
        .reg_addr(map_reg_addr)
    );

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            state <= ST_IDLE;
            remain <= `CYC_1;
            ready <= 1'b1;
            out_valid <= 1'b0;
            decoded <= 1'b0;
            no_operation <= 1'b0;
            instr_bytes <= `BYTES_1;
            instr_cycles <= `CYC_1;
            pc_load <= 1'b0;
            is_call <= 1'b0;
            branch_target <= 16'h0000;
            bit_clear <= 1'b0;
            data_addr <= 8'h00;
            data_lower <= 1'b0;
            data_upper <= 1'b0;
            data_sfr <= 1'b0;
            data_bit <= 1'b0;
            data_bit_pos <= 3'h0;
            reg_addr <= 8'h00;
            code_addr <= 16'h0000;
            code_read <= 1'b0;
            flash_write <= 1'b0;
            code_fault <= 1'b0;
        end
        else
        begin
            out_valid <= accept;
            code_read <= accept & next_code_rd & ~next_fault;
            // flash written only with write enable set
            flash_write <= accept & next_code_wr & ~next_fault & program_store_control[`STORE_WR_EN];
            if (accept)
            begin
                decoded <= next_known;
                no_operation <= next_nop;
                instr_bytes <= next_bytes;
                instr_cycles <= next_cycles;
                pc_load <= next_taken;
                is_call <= next_call;
                branch_target <= next_target;
                // set-clear variant clears bit when branching
                bit_clear <= next_has_bit_clear & next_cond_true;
                data_addr <= map_addr;
                data_lower <= map_lower;
                data_upper <= map_upper;
                data_sfr <= map_sfr;
                data_bit <= map_bit;
                data_bit_pos <= map_bit_pos;
                reg_addr <= map_reg_addr;
                code_addr <= next_code_a;
                code_fault <= (next_code_rd | next_code_wr) & next_fault;
            end
            // Ready stays low so each instruction owns its full cycle count
            case (state)
                ST_IDLE:
                    if (accept && next_cycles != `CYC_1)
                    begin
                        state <= ST_EXEC;
                        remain <= next_cycles - `CYC_1;
                        ready <= 1'b0;
                    end
                ST_EXEC:
                    if (remain == `CYC_1)
                    begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                    end
                    else
                        remain <= remain - `CYC_1;
                default:
                begin
                    state <= ST_IDLE;
                    ready <= 1'b1;
                end
            endcase
        end
    end

endmodule // citmm_decoder

// *** rtl/citmm_defs.vh ***
/*
 Constants for the instruction timing and memory map decoder: opcode
 encodings, byte and cycle counts, operand access modes and the address
 limits of program flash and data memory.
 Assumes it is included by bare name into the decoder files only.
*/
`ifndef CITMM_DEFS_VH
`define CITMM_DEFS_VH

// Opcodes with a single encoding
`define OP_NOP 8'h00
`define OP_NOP_ALT 8'ha5
`define OP_MOV_DP_IMM 8'h90
`define OP_CODE_DP 8'h93
`define OP_CODE_PC 8'h83
`define OP_XRD_DP 8'he0
`define OP_XWR_DP 8'hf0
`define OP_PUSH 8'hc0
`define OP_POP 8'hd0
`define OP_EXCH_DIR 8'hc5
`define OP_CLR_C 8'hc3
`define OP_CLR_BIT 8'hc2
`define OP_SET_C 8'hd3
`define OP_SET_BIT 8'hd2
`define OP_CPL_C 8'hb3
`define OP_CPL_BIT 8'hb2
`define OP_ANL_BIT 8'h82
`define OP_ANL_NBIT 8'hb0
`define OP_ORL_BIT 8'h72
`define OP_ORL_NBIT 8'ha0
`define OP_MOV_C_BIT 8'ha2
`define OP_MOV_BIT_C 8'h92
`define OP_JMP_CSET 8'h40
`define OP_JMP_CCLR 8'h50
`define OP_JMP_BSET 8'h20
`define OP_JMP_BCLR 8'h30
`define OP_JMP_BSC 8'h10
`define OP_LONG_CALL 8'h12
`define OP_LONG_JUMP 8'h02
`define OP_RET 8'h22
`define OP_RET_INT 8'h32
`define OP_REL_JUMP 8'h80
`define OP_JMP_IND 8'h73
`define OP_JMP_AZ 8'h60
`define OP_JMP_ANZ 8'h70
`define OP_CMPJ_DIR 8'hb5
`define OP_CMPJ_IMM 8'hb4
`define OP_DECJ_DIR 8'hd5

// Opcode groups, low bits carry the register or Ri index; short call/jump top three bits carry target bits
`define OP_XRD_RI 8'b1110_001?
`define OP_XWR_RI 8'b1111_001?
`define OP_EXCH_RN 8'b1100_1???
`define OP_EXCH_RI 8'b1100_011?
`define OP_NIBX_RI 8'b1101_011?
`define OP_CMPJ_RN 8'b1011_1???
`define OP_CMPJ_RI 8'b1011_011?
`define OP_DECJ_RN 8'b1101_1???
`define OP_SHORT_CALL 8'b???1_0001
`define OP_SHORT_JUMP 8'b???0_0001

// Instruction lengths and clock counts
`define BYTES_1 2'h1
`define BYTES_2 2'h2
`define BYTES_3 2'h3
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define CYC_5 3'h5

// Operand access modes
`define AM_NONE 3'h0
`define AM_REG 3'h1
`define AM_DIRECT 3'h2
`define AM_INDIRECT 3'h3
`define AM_BIT 3'h4

// Data memory map
`define LOWER_TOP 8'h7f
`define BIT_RAM_BASE 8'h20
`define STATUS_BANK_LO 3
`define STATUS_BANK_HI 4
`define STORE_WR_EN 0

// Program flash variants and limits
`define VAR_8K 2'h0
`define VAR_4K 2'h1
`define FLASH_8K_END 16'h2000
`define FLASH_USER_END 16'h1e00
`define FLASH_4K_END 16'h1000
`define FLASH_2K_END 16'h0800

`endif

// *** tb/citmm_checker.sv ***
/* Port checker for citmm_decoder timing and decode results.
 Assumes one clock, ref_clk, and a synchronous active-high srst. */
`timescale 1ns/10ps
module citmm_checker (
    input wire ref_clk,
    input wire srst,
    input wire instr_valid,
    input wire [7:0] opcode,
    input wire [7:0] operand_a,
    input wire [7:0] operand_b,
    input wire carry,
    input wire [7:0] program_store_control,
    input wire ready,
    input wire out_valid,
    input wire no_operation,
    input wire [1:0] instr_bytes,
    input wire [2:0] instr_cycles,
    input wire pc_load,
    input wire [15:0] branch_target,
    input wire data_lower,
    input wire data_sfr,
    input wire code_read,
    input wire flash_write,
    input wire code_fault
);
    wire take = instr_valid && ready;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_answer_next: assert property (take |=> out_valid) else $error("no answer after accept");
    a_code_pulse: assert property ((code_read || flash_write) |-> out_valid && !code_fault)
        else $error("code access pulse misplaced");
    a_flash_gate: assert property (flash_write |-> $past(program_store_control[0]))
        else $error("flash write without enable");
    a_long_wait: assert property (take && opcode == 8'h02 |=> !ready [*3] ##1 ready)
        else $error("long jump occupancy wrong");
    a_long_target: assert property (take && opcode == 8'h02 |=> pc_load && instr_bytes == 2'h3
        && branch_target == {$past(operand_a), $past(operand_b)})
        else $error("long jump result wrong");
    a_code_wait: assert property (take && opcode == 8'h93 |=> instr_cycles == 3'h3 && !ready ##1 !ready ##1 ready)
        else $error("code read occupancy wrong");
    a_nop_alt: assert property (take && opcode == 8'ha5 |=> no_operation && ready && instr_cycles == 3'h1)
        else $error("alternate no operation wrong");
    a_carry_jump: assert property (take && opcode == 8'h40 |=> pc_load == $past(carry)
        && instr_cycles == ($past(carry) ? 3'h3 : 3'h2))
        else $error("carry jump timing wrong");
    a_direct_split: assert property (take && opcode == 8'hc0 |=> data_sfr == $past(operand_a[7])
        && data_lower != $past(operand_a[7]))
        else $error("direct map wrong");
    c_long_jump: cover property (take && opcode == 8'h02);
    c_flash_write: cover property (flash_write);
    c_slow_branch: cover property (out_valid && pc_load && instr_cycles == 3'h5);
endmodule // citmm_checker

bind citmm_decoder citmm_checker u_citmm_checker (.ref_clk, .srst, .instr_valid, .opcode, .operand_a,
    .operand_b, .carry, .program_store_control, .ready, .out_valid, .no_operation, .instr_bytes,
    .instr_cycles, .pc_load, .branch_target, .data_lower, .data_sfr, .code_read, .flash_write, .code_fault);

// *** tb/testbench.sv ***
/* Self-checking bench for citmm_decoder: timing table, branches, data map, flash.
 Assumes a 100 MHz ref_clk; inputs change on the falling edge. */
`timescale 1ns/10ps
module testbench;
    reg ref_clk, srst, instr_valid, carry, bit_value, fw, cr;
    reg [7:0] opcode, operand_a, operand_b, acc_value, src_value, ri_value;
    reg [7:0] program_status_word, program_store_control;
    reg [15:0] next_pc, data_pointer;
    reg [1:0] flash_variant;
    wire ready, out_valid, decoded, no_operation, pc_load, is_call, bit_clear, data_lower, data_upper;
    wire data_sfr, data_bit, code_read, flash_write, code_fault;
    wire [1:0] instr_bytes;
    wire [2:0] instr_cycles, data_bit_pos;
    wire [7:0] data_addr, reg_addr;
    wire [15:0] branch_target, code_addr;
    integer fails, num_checks, meas, i;
    // Entries {opcode, bytes, cycles}
    localparam [511:0] TIMES = {256'h903393138313e213f313e013f013c022d022c811c522c612d612c311c222d311,
        256'hd222b311b2228222b0227222a022a22292221234023473130011a51122151123};
    // Entries {opcode, operand value, taken, cycles}
    localparam [191:0] LOOPS = 192'h1001010430010003b6070004b6080105d8010002d5020104;
    // Entries {variant, enable, address, opcode, write, read, fault}
    localparam [287:0] FLASH = 288'h000100f00010100f04011e10f01001fff932100fff9321010009312008009312007ff932;
    citmm_decoder u_citmm_decoder (.ref_clk, .srst, .instr_valid, .opcode, .operand_a, .operand_b, .next_pc,
        .acc_value, .carry, .bit_value, .src_value, .ri_value, .data_pointer, .program_status_word,
        .program_store_control, .flash_variant, .ready, .out_valid, .decoded, .no_operation, .instr_bytes,
        .instr_cycles, .pc_load, .is_call, .branch_target, .bit_clear, .data_addr, .data_lower, .data_upper,
        .data_sfr, .data_bit, .data_bit_pos, .reg_addr, .code_addr, .code_read, .flash_write, .code_fault);
    task chk(input [31:0] s, input [31:0] e);
    begin
        num_checks = num_checks + 1;
        if (s !== e)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // Pulsed outputs are caught in the answer cycle; meas counts occupancy
    task issue(input [7:0] op, input [7:0] a, input [7:0] b);
    begin
        {opcode, operand_a, operand_b, instr_valid} = {op, a, b, 1'b1};
        @(negedge ref_clk);
        {fw, cr} = {flash_write, code_read};
        chk(out_valid, 1'b1);
        meas = 1;
        while (ready !== 1'b1 && meas < 9)
        begin
            @(negedge ref_clk);
            meas = meas + 1;
        end
        if (meas == 9)
        begin
            fails = fails + 1;
            end_sim;
        end
    end
    endtask
    task t_table;
    begin
        for (i = 0; i < 32; i = i + 1)
        begin
            issue(TIMES[i*16+8 +: 8], 8'h85, 8'h00);
            chk(instr_bytes, TIMES[i*16+4 +: 4]);
            chk(instr_cycles, TIMES[i*16 +: 4]);
            chk(meas, TIMES[i*16 +: 4]);
            chk({decoded, no_operation}, {1'b1, TIMES[i*16+8 +: 8] == 8'h00 || TIMES[i*16+8 +: 8] == 8'ha5});
        end
        $display("t_table done");
    end
    endtask
    task t_cond;
    begin
        next_pc = 16'h0100;
        for (i = 0; i < 8; i = i + 1)
        begin
            {carry, acc_value} = {i[0], i[0] ? 8'h00 : 8'h05};
            issue(8'h40 + i[2:1] * 8'h10, 8'hf0, 8'h00);
            chk(pc_load, i[0] ^ i[1]);
            chk(meas, 2 + (i[0] ^ i[1]));
            if (i[0] ^ i[1])
                chk(branch_target, 16'h00f0);
        end
        $display("t_cond done");
    end
    endtask
    task t_loops;
    begin
        next_pc = 16'h0200;
        for (i = 0; i < 6; i = i + 1)
        begin
            {src_value, bit_value} = {LOOPS[i*32+16 +: 8], LOOPS[i*32+16]};
            issue(LOOPS[i*32+24 +: 8], 8'h07, 8'h10);
            chk(meas, LOOPS[i*32 +: 8]);
            chk(pc_load, LOOPS[i*32+8 +: 8]);
            chk(bit_clear, LOOPS[i*32+24 +: 8] == 8'h10);
            if (LOOPS[i*32+24 +: 4] == 4'h0)
                chk({data_bit, data_addr, data_bit_pos}, 12'h907);
        end
        $display("t_loops done");
    end
    endtask
    task t_jumps;
    begin
        next_pc = 16'h1802;
        issue(8'h61, 8'h45, 8'h00);
        chk({is_call, branch_target}, 17'h01b45);
        issue(8'h71, 8'h45, 8'h00);
        chk({is_call, branch_target}, 17'h11b45);
        issue(8'h12, 8'h12, 8'h34);
        chk({is_call, branch_target}, 17'h11234);
        {acc_value, data_pointer, next_pc} = {8'h10, 16'h0300, 16'h0100};
        issue(8'h73, 8'h00, 8'h00);
        chk(branch_target, 16'h0310);
        issue(8'h80, 8'h7f, 8'h00);
        chk(branch_target, 16'h017f);
        $display("t_jumps done");
    end
    endtask
    task t_data;
    begin
        {program_status_word, ri_value} = {8'h10, 8'h90};
        issue(8'hcd, 8'h00, 8'h00);
        chk(reg_addr, 8'h15);
        issue(8'hc0, 8'h85, 8'h00);
        chk({data_sfr, data_lower, data_addr}, 10'h285);
        issue(8'hc0, 8'h7f, 8'h00);
        chk({data_sfr, data_lower, data_addr}, 10'h17f);
        issue(8'hc6, 8'h00, 8'h00);
        chk({data_upper, data_sfr, reg_addr}, 10'h210);
        issue(8'h24, 8'h00, 8'h00);
        chk({decoded, instr_bytes, instr_cycles}, 6'h09);
        $display("t_data done");
    end
    endtask
    task t_flash;
    begin
        acc_value = 8'h00;
        for (i = 0; i < 8; i = i + 1)
        begin
            {flash_variant, program_store_control, data_pointer} =
                {FLASH[i*36+32 +: 2], 4'h0, FLASH[i*36+28 +: 4], FLASH[i*36+12 +: 16]};
            issue(FLASH[i*36+4 +: 8], 8'h00, 8'h00);
            chk({fw, cr, code_fault}, FLASH[i*36 +: 3]);
            chk(code_addr, FLASH[i*36+12 +: 16]);
        end
        $display("t_flash done");
    end
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        {fails, num_checks, srst} = {32'h0, 32'h0, 1'b1};
        {instr_valid, carry, bit_value, opcode, operand_a, operand_b, acc_value, src_value} = '0;
        {ri_value, program_status_word, program_store_control, next_pc, data_pointer, flash_variant} = '0;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        chk({ready, out_valid, instr_cycles}, 5'h11);
        t_table;
        t_cond;
        t_loops;
        t_jumps;
        t_data;
        t_flash;
        end_sim;
    end
endmodule // testbench
